// file: logic/adc_device_end.sv
`timescale 1ns/1ps
// Operation
// - Bipolar words two's complement, saturating
// - Unipolar words offset binary, saturating
// - Role high: device makes and drives sclk
// - Self-clocked, chip select high: sclk and sdo float, ready stays driven
// - Chip select low at load: word shifts out
// - Data changes on rising edge, captured next
// - Self-clocked: ready rises after last bit
// - Role low: host makes every sclk edge
// - External clock: word loads as ready falls
// - Host may hold chip select low always
// - Word held until started read completes
// - Unread word overwritten by next conversion
// - Unread, selected: ready rises before next load
// - Ready rises two cycles before completion
// - Conversion lasts eighty master clock cycles
module adc_device_end (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                reset,
  // Straps and conversion
  input  wire logic                                port_role_select,
  input  wire logic                                polarity_select,
  input  wire logic                                convert_request_n,
  input  wire logic signed [adc_port_pkg::SAMPLE_W-1:0] sample_in,
  // Status
  output logic                                     converting,
  output logic                                     word_unread,
  // Link
  adc_link_if.device                               link
);

  logic [3:0]                      pin_s1_r, pin_s2_r;
  logic [1:0]                      tog_s1_r, tog_s2_r;
  logic [1:0]                      tog_seen_r;
  logic                            cs_s, convert_request_n_req_s, self_mode_s, bipolar_s;
  logic                            frame_start, frame_done;
  logic                            busy_r, busy_nxt;
  logic [adc_port_pkg::CONVERT_REQUEST_N_W-1:0] convert_request_n_cnt_r, convert_request_n_cnt_nxt;
  logic                            complete;
  logic [adc_port_pkg::WORD_W-1:0] coded;
  logic [adc_port_pkg::WORD_W-1:0] port_word_r, port_word_nxt;
  logic [adc_port_pkg::WORD_W-1:0] defer_word_r, defer_word_nxt;
  logic                            defer_r, defer_nxt;
  logic                            load;
  logic                            ready_n_r, ready_n_nxt;
  logic                            unread_r, unread_nxt;
  logic                            reading_r, reading_nxt;
  logic                            gen_r, gen_nxt;
  logic [adc_port_pkg::HALF_W-1:0] half_r, half_nxt;
  logic                            sclk_r, sclk_nxt;
  logic                            sclk_oe_r, sdo_oe_r;
  logic [adc_port_pkg::CNT_W-1:0]  bit_cnt_r, bit_cnt_nxt;
  logic                            sdo_r, sdo_nxt;
  logic                            start_tog_r, start_tog_nxt;
  logic                            done_tog_r, done_tog_nxt;
  logic                            frame_clr;

  assign cs_s        = pin_s2_r[0];
  assign convert_request_n_req_s  = pin_s2_r[1];
  assign self_mode_s = pin_s2_r[2];
  assign bipolar_s   = pin_s2_r[3];
  assign frame_start = tog_s2_r[0] ^ tog_seen_r[0];
  assign frame_done  = tog_s2_r[1] ^ tog_seen_r[1];
  assign complete    = busy_r && (convert_request_n_cnt_r == adc_port_pkg::CONVERT_REQUEST_N_LAST);
  assign coded       = adc_port_pkg::code_word(sample_in, bipolar_s);
  assign frame_clr   = reset | link.cs_n;

  assign converting       = busy_r;
  assign word_unread      = unread_r;
  assign link.ready_n     = ready_n_r;
  assign link.sclk_dev_o  = sclk_r;
  assign link.sclk_dev_oe = sclk_oe_r;
  assign link.sdo_o       = sdo_r;
  assign link.sdo_oe      = sdo_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin and crossing synchronisers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_s1_r   <= 4'h3;
      pin_s2_r   <= 4'h3;
      tog_s1_r   <= 2'h0;
      tog_s2_r   <= 2'h0;
      tog_seen_r <= 2'h0;
    end
    else
    begin
      pin_s1_r   <= {polarity_select, port_role_select, convert_request_n, link.cs_n};
      pin_s2_r   <= pin_s1_r;
      tog_s1_r   <= {done_tog_r, start_tog_r};
      tog_s2_r   <= tog_s1_r;
      tog_seen_r <= tog_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion timer
  always_comb
  begin
    busy_nxt     = busy_r;
    convert_request_n_cnt_nxt = convert_request_n_cnt_r;
    if (busy_r)
      convert_request_n_cnt_nxt = convert_request_n_cnt_r + 7'h01;
    if (complete)
    begin
      busy_nxt     = ~convert_request_n_req_s;
      convert_request_n_cnt_nxt = '0;
    end
    else if (!busy_r && !convert_request_n_req_s)
    begin
      busy_nxt     = 1'b1;
      convert_request_n_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy_r     <= 1'b0;
      convert_request_n_cnt_r <= '0;
    end
    else
    begin
      busy_r     <= busy_nxt;
      convert_request_n_cnt_r <= convert_request_n_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port register, ready and read tracking
  always_comb
  begin
    port_word_nxt  = port_word_r;
    defer_word_nxt = defer_word_r;
    defer_nxt      = defer_r;
    ready_n_nxt    = ready_n_r;
    unread_nxt     = unread_r;
    reading_nxt    = reading_r;
    load           = 1'b0;
    if (frame_done)
    begin
      reading_nxt = 1'b0;
      ready_n_nxt = 1'b1;
    end
    if (frame_start)
    begin
      reading_nxt = 1'b1;
      unread_nxt  = 1'b0;
    end
    if (unread_r && !cs_s && busy_r && convert_request_n_cnt_r == adc_port_pkg::READY_RISE_AT)
      ready_n_nxt = 1'b1;
    if (complete && (reading_r || frame_start))
    begin
      defer_nxt      = 1'b1;
      defer_word_nxt = coded;
    end
    else if (complete)
    begin
      load          = 1'b1;
      port_word_nxt = coded;
    end
    else if (defer_r && frame_done)
    begin
      load          = 1'b1;
      defer_nxt     = 1'b0;
      port_word_nxt = defer_word_r;
    end
    if (load)
    begin
      ready_n_nxt = 1'b0;
      unread_nxt  = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      port_word_r  <= '0;
      defer_word_r <= '0;
      defer_r      <= 1'b0;
      ready_n_r    <= 1'b1;
      unread_r     <= 1'b0;
      reading_r    <= 1'b0;
    end
    else
    begin
      port_word_r  <= port_word_nxt;
      defer_word_r <= defer_word_nxt;
      defer_r      <= defer_nxt;
      ready_n_r    <= ready_n_nxt;
      unread_r     <= unread_nxt;
      reading_r    <= reading_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-clocked sclk generator
  always_comb
  begin
    gen_nxt  = gen_r;
    half_nxt = half_r;
    sclk_nxt = 1'b0;
    if (gen_r)
    begin
      sclk_nxt = ~sclk_r;
      half_nxt = half_r + 6'h01;
      if (half_r == adc_port_pkg::HALF_LAST)
      begin
        gen_nxt  = 1'b0;
        sclk_nxt = 1'b0;
      end
    end
    else if (load && self_mode_s && !cs_s)
    begin
      gen_nxt  = 1'b1;
      half_nxt = '0;
    end
    if (cs_s)
      gen_nxt = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      gen_r     <= 1'b0;
      half_r    <= '0;
      sclk_r    <= 1'b0;
      sclk_oe_r <= 1'b0;
      sdo_oe_r  <= 1'b0;
    end
    else
    begin
      gen_r     <= gen_nxt;
      half_r    <= half_nxt;
      sclk_r    <= sclk_nxt;
      sclk_oe_r <= self_mode_s & ~cs_s;
      sdo_oe_r  <= ~cs_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side shifter on the sclk wire
  always_comb
  begin
    bit_cnt_nxt   = bit_cnt_r + 5'h01;
    sdo_nxt       = sdo_r;
    start_tog_nxt = start_tog_r;
    done_tog_nxt  = done_tog_r;
    if (bit_cnt_r < adc_port_pkg::DATA_EDGES)
      sdo_nxt = port_word_r[adc_port_pkg::MSB_IDX - bit_cnt_r[3:0]];
    if (bit_cnt_r == '0)
      start_tog_nxt = ~start_tog_r;
    if (bit_cnt_r == adc_port_pkg::FRAME_LAST)
    begin
      bit_cnt_nxt  = '0;
      done_tog_nxt = ~done_tog_r;
    end
  end

  always_ff @(posedge link.sclk or posedge frame_clr)
  begin
    if (frame_clr)
      bit_cnt_r <= '0;
    else
      bit_cnt_r <= bit_cnt_nxt;
  end

  always_ff @(posedge link.sclk or posedge reset)
  begin
    if (reset)
    begin
      sdo_r       <= 1'b0;
      start_tog_r <= 1'b0;
      done_tog_r  <= 1'b0;
    end
    else
    begin
      sdo_r       <= sdo_nxt;
      start_tog_r <= start_tog_nxt;
      done_tog_r  <= done_tog_nxt;
    end
  end

endmodule : adc_device_end

// file: common/adc_port_pkg.sv
package adc_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int WORD_W    = 16;
  localparam int SAMPLE_W  = 18;
  localparam int CNT_W     = 5;
  localparam int CONVERT_REQUEST_N_W    = 7;
  localparam int HALF_W    = 6;
  localparam int BUF_DEPTH = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion timing in master clock cycles
  localparam logic [CONVERT_REQUEST_N_W-1:0] CONVERT_REQUEST_N_CYCLES   = 7'h50;
  localparam logic [CONVERT_REQUEST_N_W-1:0] READY_LEAD    = 7'h02;
  localparam logic [CONVERT_REQUEST_N_W-1:0] CONVERT_REQUEST_N_LAST     = CONVERT_REQUEST_N_CYCLES - 7'h01;
  localparam logic [CONVERT_REQUEST_N_W-1:0] READY_RISE_AT = CONVERT_REQUEST_N_LAST - READY_LEAD;

  ////////////////////////////////////////////////////////////////////////////
  // Frame: one launch edge, sixteen capture edges
  localparam logic [CNT_W-1:0]  FRAME_LAST = 5'h10;
  localparam logic [CNT_W-1:0]  DATA_EDGES = 5'h10;
  localparam logic [3:0]        MSB_IDX    = 4'hF;
  localparam logic [HALF_W-1:0] HALF_LAST  = 6'h21;

  ////////////////////////////////////////////////////////////////////////////
  // Output codes
  localparam logic [WORD_W-1:0]          BIP_MAX = 16'h7FFF;
  localparam logic [WORD_W-1:0]          BIP_MIN = 16'h8000;
  localparam logic [WORD_W-1:0]          UNI_MAX = 16'hFFFF;
  localparam logic [WORD_W-1:0]          UNI_MIN = 16'h0000;
  localparam logic [WORD_W-1:0]          UNI_MID = 16'h8000;
  localparam logic signed [SAMPLE_W-1:0] SAT_HI  = 18'sh07FFF;
  localparam logic signed [SAMPLE_W-1:0] SAT_LO  = 18'sh38000;

  typedef enum logic [1:0] {H_IDLE, H_SELECT, H_CLOCK, H_FINISH} host_state_t;

  // Saturating output coding
  function automatic logic [WORD_W-1:0] code_word(input logic signed [SAMPLE_W-1:0] s,
                                                   input logic bipolar);
    logic [WORD_W-1:0] w;
    w = s[WORD_W-1:0];
    if (bipolar)
    begin
      if (s > SAT_HI)
        w = BIP_MAX;
      else if (s < SAT_LO)
        w = BIP_MIN;
    end
    else
    begin
      if (s > SAT_HI)
        w = UNI_MAX;
      else if (s < SAT_LO)
        w = UNI_MIN;
      else
        w = s[WORD_W-1:0] ^ UNI_MID;
    end
    return w;
  endfunction : code_word

endpackage : adc_port_pkg

// file: common/adc_link_if.sv
`timescale 1ns/1ps
interface adc_link_if;
  logic sclk_dev_o;
  logic sclk_dev_oe;
  logic sclk_host_o;
  logic sclk_host_oe;
  logic sdo_o;
  logic sdo_oe;
  logic cs_n;
  logic ready_n;
  logic sclk;
  logic sdo;

  // Wire levels, pull-down when floating
  assign sclk = sclk_dev_oe ? sclk_dev_o : (sclk_host_oe ? sclk_host_o : 1'b0);
  assign sdo  = sdo_oe ? sdo_o : 1'b0;

  modport device (
    input  sclk,
    input  cs_n,
    output sclk_dev_o,
    output sclk_dev_oe,
    output sdo_o,
    output sdo_oe,
    output ready_n
  );

  modport host (
    input  sclk,
    input  sdo,
    input  ready_n,
    output sclk_host_o,
    output sclk_host_oe,
    output cs_n
  );
endinterface : adc_link_if

// file: logic/word_buffer.sv
`timescale 1ns/1ps
module word_buffer #(
  parameter int WIDTH = adc_port_pkg::WORD_W,
  parameter int DEPTH = adc_port_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] dat_r   [DEPTH];
  logic [WIDTH-1:0] dat_nxt [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] vld_nxt;
  logic             push;
  logic             pop;
  logic             placed;

  assign in_ready  = ~vld_r[DEPTH-1];
  assign out_valid = vld_r[0];
  assign out_data  = dat_r[0];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Shift toward head, then fill first free slot
  always_comb
  begin
    placed  = 1'b0;
    vld_nxt = vld_r;
    for (int i = 0; i < DEPTH; i++)
      dat_nxt[i] = dat_r[i];
    if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        vld_nxt[i] = vld_r[i+1];
        dat_nxt[i] = dat_r[i+1];
      end
      vld_nxt[DEPTH-1] = 1'b0;
    end
    for (int i = 0; i < DEPTH; i++)
    begin
      if (push && !placed && !vld_nxt[i])
      begin
        vld_nxt[i] = 1'b1;
        dat_nxt[i] = in_data;
        placed     = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      vld_r <= '0;
    else
      vld_r <= vld_nxt;
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_entry
      always_ff @(posedge clk)
      begin
        dat_r[g] <= dat_nxt[g];
      end
    end
  endgenerate

endmodule : word_buffer

// file: logic/adc_host_end.sv
`timescale 1ns/1ps
module adc_host_end (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // Mode
  input  wire logic                      self_clocked_mode,
  input  wire logic                      keep_cs_low,
  // Received words
  output logic [adc_port_pkg::WORD_W-1:0] word_out,
  output logic                           word_valid,
  input  wire logic                      word_ready,
  // Link
  adc_link_if.host                       link
);

  adc_port_pkg::host_state_t state_r, state_nxt;
  logic [adc_port_pkg::HALF_W-1:0] half_r, half_nxt;
  logic                            sclk_r, sclk_nxt;
  logic                            cs_n_r, cs_n_nxt;
  logic                            oe_r;
  logic [1:0]                      rdy_s1_r, rdy_s2_r;
  logic [1:0]                      tog_s1_r, tog_s2_r;
  logic                            tog_seen_r;
  logic                            arrive;
  logic                            buf_in_ready;
  logic [adc_port_pkg::CNT_W-1:0]  cap_cnt_r, cap_cnt_nxt;
  logic [adc_port_pkg::WORD_W-1:0] shift_r, shift_nxt;
  logic [adc_port_pkg::WORD_W-1:0] word_r, word_nxt;
  logic                            word_tog_r, word_tog_nxt;
  logic                            frame_clr;

  assign link.sclk_host_o  = sclk_r;
  assign link.sclk_host_oe = oe_r;
  assign link.cs_n         = cs_n_r;
  assign arrive            = tog_s2_r[0] ^ tog_seen_r;
  assign frame_clr         = reset | cs_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into clk
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdy_s1_r   <= 2'h3;
      rdy_s2_r   <= 2'h3;
      tog_s1_r   <= 2'h0;
      tog_s2_r   <= 2'h0;
      tog_seen_r <= 1'b0;
    end
    else
    begin
      rdy_s1_r   <= {1'b0, link.ready_n};
      rdy_s2_r   <= {rdy_s2_r[0], rdy_s1_r[0]};
      tog_s1_r   <= {1'b0, word_tog_r};
      tog_s2_r   <= tog_s1_r;
      tog_seen_r <= tog_s2_r[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read sequencer, sclk from clk divided by two
  always_comb
  begin
    state_nxt = state_r;
    half_nxt  = half_r;
    sclk_nxt  = 1'b0;
    cs_n_nxt  = cs_n_r;
    unique case (state_r)
      adc_port_pkg::H_IDLE:
      begin
        if (self_clocked_mode)
        begin
          if (buf_in_ready)
            cs_n_nxt = 1'b0;
          else if (rdy_s2_r[0])
            cs_n_nxt = 1'b1;
        end
        else if (rdy_s2_r[1] && !rdy_s2_r[0] && buf_in_ready)
        begin
          cs_n_nxt  = 1'b0;
          state_nxt = adc_port_pkg::H_SELECT;
        end
        else
          cs_n_nxt = ~keep_cs_low;
      end
      adc_port_pkg::H_SELECT:
      begin
        half_nxt  = '0;
        state_nxt = adc_port_pkg::H_CLOCK;
      end
      adc_port_pkg::H_CLOCK:
      begin
        sclk_nxt = ~sclk_r;
        half_nxt = half_r + 6'h01;
        if (half_r == adc_port_pkg::HALF_LAST)
        begin
          sclk_nxt  = 1'b0;
          state_nxt = adc_port_pkg::H_FINISH;
        end
      end
      adc_port_pkg::H_FINISH:
      begin
        cs_n_nxt = ~keep_cs_low;
        if (rdy_s2_r[0])
          state_nxt = adc_port_pkg::H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= adc_port_pkg::H_IDLE;
      half_r  <= '0;
      sclk_r  <= 1'b0;
      cs_n_r  <= 1'b1;
      oe_r    <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      half_r  <= half_nxt;
      sclk_r  <= sclk_nxt;
      cs_n_r  <= cs_n_nxt;
      oe_r    <= ~self_clocked_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture on sclk, edges two to seventeen
  always_comb
  begin
    cap_cnt_nxt  = cap_cnt_r + 5'h01;
    shift_nxt    = shift_r;
    word_nxt     = word_r;
    word_tog_nxt = word_tog_r;
    if (cap_cnt_r != '0)
      shift_nxt = {shift_r[adc_port_pkg::WORD_W-2:0], link.sdo};
    if (cap_cnt_r == adc_port_pkg::FRAME_LAST)
    begin
      cap_cnt_nxt  = '0;
      word_nxt     = shift_nxt;
      word_tog_nxt = ~word_tog_r;
    end
  end

  always_ff @(posedge link.sclk or posedge frame_clr)
  begin
    if (frame_clr)
      cap_cnt_r <= '0;
    else
      cap_cnt_r <= cap_cnt_nxt;
  end

  always_ff @(posedge link.sclk or posedge reset)
  begin
    if (reset)
    begin
      shift_r    <= '0;
      word_r     <= '0;
      word_tog_r <= 1'b0;
    end
    else
    begin
      shift_r    <= shift_nxt;
      word_r     <= word_nxt;
      word_tog_r <= word_tog_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Received word queue
  word_buffer u_buffer (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (arrive),
    .in_ready  (buf_in_ready),
    .in_data   (word_r),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_out)
  );

endmodule : adc_host_end

// file: bench/adc_serial_output_port_properties.sv
`timescale 1ns/1ps
module adc_link_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Strap
  input wire logic port_role_select,
  // Link
  input wire logic sclk_dev_oe,
  input wire logic sclk_host_oe,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic cs_n,
  input wire logic ready_n,
  input wire logic sclk
);
  //////////////////////////////////////////////////////////////////////////////
  // Edge and ready tracking
  logic       sclk_q_r;
  logic       rdy_q_r;
  logic [4:0] edge_cnt_r;
  logic [4:0] edge_cnt_nxt;
  logic [6:0] since_fall_r;
  logic [6:0] since_fall_nxt;
  logic       seen_fall_r;
  logic       seen_fall_nxt;
  logic       frame_seen_r;
  logic       frame_seen_nxt;
  logic       sclk_rise;
  logic       frame_end;
  logic       rdy_fall;

  always_comb
  begin
    sclk_rise    = sclk && !sclk_q_r;
    frame_end    = sclk_rise && (edge_cnt_r == 5'h10);
    rdy_fall     = !ready_n && rdy_q_r;
    edge_cnt_nxt = edge_cnt_r;
    if (cs_n || frame_end)
      edge_cnt_nxt = 5'h00;
    else if (sclk_rise)
      edge_cnt_nxt = edge_cnt_r + 5'h01;
    since_fall_nxt = (since_fall_r == 7'h7F) ? since_fall_r : since_fall_r + 7'h01;
    if (rdy_fall)
      since_fall_nxt = 7'h00;
    seen_fall_nxt  = seen_fall_r || rdy_fall;
    frame_seen_nxt = rdy_fall ? 1'b0 : (frame_seen_r || frame_end);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sclk_q_r     <= 1'b0;
      rdy_q_r      <= 1'b1;
      edge_cnt_r   <= 5'h00;
      since_fall_r <= 7'h00;
      seen_fall_r  <= 1'b0;
      frame_seen_r <= 1'b0;
    end
    else
    begin
      sclk_q_r     <= sclk;
      rdy_q_r      <= ready_n;
      edge_cnt_r   <= edge_cnt_nxt;
      since_fall_r <= since_fall_nxt;
      seen_fall_r  <= seen_fall_nxt;
      frame_seen_r <= frame_seen_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_self_start;
    (!cs_n) [*4] ##0 ($fell(ready_n) && port_role_select) |-> ##[1:3] (sclk_dev_oe && sclk_rise);
  endproperty
  a_self_start: assert property (p_self_start) else $error("No self clock after load");

  property p_cs_float;
    cs_n [*5] |-> !sdo_oe && !sclk_dev_oe;
  endproperty
  a_cs_float: assert property (p_cs_float) else $error("Port driven while deselected");

  property p_sdo_on_rise;
    !cs_n && $past(!cs_n) && sdo_oe && $changed(sdo_o) |-> sclk_rise;
  endproperty
  a_sdo_on_rise: assert property (p_sdo_on_rise) else $error("Data moved off rising edge");

  property p_ready_after_frame;
    frame_end |-> ##[2:6] ready_n;
  endproperty
  a_ready_after_frame: assert property (p_ready_after_frame) else $error("Ready not raised");

  property p_slave_clock;
    !port_role_select && sclk_rise |-> sclk_host_oe && !sclk_dev_oe;
  endproperty
  a_slave_clock: assert property (p_slave_clock) else $error("Device drove clock as slave");

  property p_frame_holds;
    edge_cnt_r != 5'h00 |-> !ready_n;
  endproperty
  a_frame_holds: assert property (p_frame_holds) else $error("Ready rose during a read");

  property p_early_rise;
    $rose(ready_n) && !frame_seen_r && seen_fall_r |-> ##1 ready_n ##1 !ready_n;
  endproperty
  a_early_rise: assert property (p_early_rise) else $error("Early ready pulse wrong");

  property p_convert_request_n_spacing;
    rdy_fall && seen_fall_r |-> since_fall_r >= 7'h4F;
  endproperty
  a_convert_request_n_spacing: assert property (p_convert_request_n_spacing) else $error("Conversions too close");

  c_frame: cover property (frame_end);
  c_early: cover property ($rose(ready_n) && !frame_seen_r && seen_fall_r);
  c_float: cover property (port_role_select && cs_n [*5]);
endmodule : adc_link_checker

// file: bench/tb_adc_serial_output_port.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module tb_adc_serial_output_port;
  logic                                       clk = 1'b0;
  logic                                       reset = 1'b1;
  logic                                       port_role_select = 1'b0;
  logic                                       polarity_select = 1'b0;
  logic                                       convert_request_n = 1'b1;
  logic                                       keep_cs_low = 1'b0;
  logic                                       word_ready = 1'b0;
  logic signed [adc_port_pkg::SAMPLE_W-1:0]   sample_in = 18'sh00000;
  logic        [adc_port_pkg::WORD_W-1:0]     word_out;
  logic                                       word_valid;
  logic        [15:0]                         sniff_r = 16'h0000;
  logic signed [17:0]                         samples [6] = '{18'sh09C40, 18'sh07FFF,
    18'sh00000, 18'sh3FFFF, 18'sh38001, 18'sh363C0};
  logic        [15:0]                         codes [2][6] = '{
    '{16'hFFFF, 16'hFFFF, 16'h8000, 16'h7FFF, 16'h0001, 16'h0000},
    '{16'h7FFF, 16'h7FFF, 16'h0000, 16'hFFFF, 16'h8001, 16'h8000}};
  int                                         n_mismatch = 0;
  int                                         samples_checked = 0;
  int                                         cycles = 0;

  //////////////////////////////////////////////////////////////////////////////
  // Clock, timeout, wire sniffer
  always #25 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Both ends and checker
  adc_link_if link_if ();

  always @(posedge link_if.sclk)
    if (!link_if.cs_n)
      sniff_r <= {sniff_r[14:0], link_if.sdo};

  adc_device_end u_adc_device_end (.clk(clk), .reset(reset), .port_role_select(port_role_select),
    .polarity_select(polarity_select), .convert_request_n(convert_request_n),
    .sample_in(sample_in), .converting(), .word_unread(), .link(link_if.device));

  adc_host_end u_adc_host_end (.clk(clk), .reset(reset), .self_clocked_mode(port_role_select),
    .keep_cs_low(keep_cs_low), .word_out(word_out), .word_valid(word_valid),
    .word_ready(word_ready), .link(link_if.host));

  adc_link_checker u_adc_link_checker (.clk(clk), .reset(reset),
    .port_role_select(port_role_select), .sclk_dev_oe(link_if.sclk_dev_oe),
    .sclk_host_oe(link_if.sclk_host_oe), .sdo_o(link_if.sdo_o), .sdo_oe(link_if.sdo_oe),
    .cs_n(link_if.cs_n), .ready_n(link_if.ready_n), .sclk(link_if.sclk));

  //////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step

  task automatic restart(input logic role);
    reset = 1'b1;
    port_role_select = role;
    convert_request_n = 1'b1;
    step(5);
    reset = 1'b0;
    step(2);
  endtask : restart

  task automatic read_word(input logic [15:0] exp);
    int n;
    n = 0;
    while (word_valid !== 1'b1 && n < 400)
    begin
      step(1);
      n++;
    end
    `CHK(word_out, exp)
    word_ready = 1'b1;
    step(1);
    word_ready = 1'b0;
    step(1);
  endtask : read_word

  task automatic overwrite_run(input logic role);
    restart(role);
    keep_cs_low = 1'b1;
    polarity_select = 1'b1;
    sample_in = 18'sh01234;
    convert_request_n = 1'b0;
    step(300);
    sample_in = 18'sh3EDCC;
    step(300);
    read_word(16'h1234);
    read_word(16'h1234);
    read_word(16'hEDCC);
    convert_request_n = 1'b1;
    step(200);
  endtask : overwrite_run

  task automatic end_sim();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    for (int r = 0; r < 2; r++)
    begin
      restart(r[0]);
      keep_cs_low = 1'b0;
      for (int p = 0; p < 2; p++)
        for (int i = 0; i < 6; i++)
        begin
          polarity_select = p[0];
          sample_in = samples[i];
          convert_request_n = 1'b0;
          step(4);
          convert_request_n = 1'b1;
          read_word(codes[p][i]);
          `CHK(sniff_r, codes[p][i])
        end
    end
    overwrite_run(1'b0);
    overwrite_run(1'b1);
    end_sim();
  end
endmodule : tb_adc_serial_output_port
